/* File: rtl/fieldbus_status_word_builder.sv */
`timescale 1ns/1ns
`include "fsw_params.svh"
`default_nettype none
module fieldbus_status_word_builder #(
  parameter int TICK_CYCLES = `FILT_TICK_US * `CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  input wire logic error_active_i,
  input wire logic regulator_auto_i,
  input wire logic undervoltage_i,
  input wire logic remote_i,
  input wire logic jog_i,
  input wire logic cw_i,
  input wire logic gen_enable_i,
  input wire logic run_i,
  input wire logic [7:0] fault_code_i,
  input wire logic [12:0] speed_mag_i,
  input wire logic signed [15:0] torque_current_i,
  input wire logic signed [15:0] motor_current_i,
  input wire logic [7:0] digital_input_i,
  input wire logic link_up_i,
  input wire logic board_ok_i,
  input wire logic exchange_req_i,
  input wire logic [9:0] param_num_i,
  input wire logic net_write_i,
  input wire fsw_pkg::word_t net_ctrl_i,
  input wire fsw_pkg::word_t net_ref_i,
  output fsw_pkg::word_t word0_o,
  output fsw_pkg::word_t word1_o,
  output fsw_pkg::word_t word2_o,
  output fsw_pkg::word_t word3_o,
  output fsw_pkg::word_t word4_o,
  output fsw_pkg::word_t word5_o,
  output logic words_valid_o,
  output logic [2:0] word_count_o,
  output fsw_pkg::word_t held_ctrl_o,
  output fsw_pkg::word_t held_ref_o,
  output logic ramp_stop_o,
  output logic coast_stop_o,
  output logic keep_state_o,
  output logic go_local_o,
  output logic go_local_keep_o,
  output logic link_lost_error_o,
  output logic board_off_error_o
);
  import fsw_pkg::*;

  localparam logic [16:0] ALPHA_TQ =
    17'((`ALPHA_ONE * `FILT_TICK_US) / (`TAU_TORQUE_MS * 1000));
  localparam logic [16:0] ALPHA_MC =
    17'((`ALPHA_ONE * `FILT_TICK_US) / (`TAU_MOTOR_MS * 1000));

  function automatic logic [2:0] word_count(input logic [3:0] p);
    if (p >= `PROTO_A_2 && p <= `PROTO_C_6)
      word_count = 3'(((p - `PROTO_A_2) % 4'h3) * 4'h2 + 4'h2);
    else if (p == `PROTO_B_PROFILE)
      word_count = `CNT_4;
    else
      word_count = `CNT_0;
  endfunction

  function automatic logic [1:0] family(input logic [3:0] p);
    if (p >= `PROTO_A_2 && p <= `PROTO_A_6)
      family = `FAM_A;
    else if ((p >= `PROTO_B_2 && p <= `PROTO_B_6) || p == `PROTO_B_PROFILE)
      family = `FAM_B;
    else if (p >= `PROTO_C_2 && p <= `PROTO_C_6)
      family = `FAM_C;
    else
      family = `FAM_NONE;
  endfunction

  function automatic word_t drive_state(input logic err, input logic [7:0] code,
                                        input logic uv, input logic run);
    if (err && !(code >= `FAULT_ACCESS_LO && code <= `FAULT_ACCESS_HI))
      drive_state = `DSTATE_FAULT;
    else if (uv)
      drive_state = `DSTATE_UNDERVOLT;
    else if (run)
      drive_state = `DSTATE_RUN;
    else
      drive_state = `DSTATE_READY;
  endfunction

  core_state_t s;
  core_state_t n;
  logic setup;
  logic access;
  logic active;
  logic offline;
  logic rejoin;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  word_t mem_rdata;
  word_t tq_filt;
  word_t mc_filt;
  word_t status_w;
  word_t speed_w;
  word_t image_w;
  word_t param_w;

  fsw_param_mem u_mem (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .we_i(s.mem_we),
    .waddr_i(s.mem_waddr),
    .wdata_i(s.mem_wdata),
    .raddr_i(param_num_i),
    .rdata_o(mem_rdata)
  );

  fsw_lp_filter #(.ALPHA(ALPHA_TQ)) u_tq_filt (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .tick_i(s.tick),
    .x_i(torque_current_i),
    .y_o(tq_filt)
  );

  fsw_lp_filter #(.ALPHA(ALPHA_MC)) u_mc_filt (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .tick_i(s.tick),
    .x_i(motor_current_i),
    .y_o(mc_filt)
  );

  always_comb
  begin
    status_w = {error_active_i, regulator_auto_i, undervoltage_i,
                remote_i, jog_i, cw_i, gen_enable_i, run_i,
                error_active_i ? fault_code_i : 8'h00};
    speed_w = cw_i ? {3'b000, speed_mag_i} : -{3'b000, speed_mag_i};
    image_w = {8'h00, s.di_s2[0], s.di_s2[1], s.di_s2[2], s.di_s2[3],
               3'b000, s.di_s2[7]};
    // stored values already carry the full one-decimal scaling
    if (param_num_i == `PNUM_DRIVE_STATE)
      param_w = drive_state(error_active_i, fault_code_i, undervoltage_i, run_i);
    else if (param_num_i == `PNUM_INPUT_IMG)
      param_w = image_w;
    else if (param_num_i == `PNUM_TORQUE_CUR)
      param_w = tq_filt;
    else if (param_num_i == `PNUM_MOTOR_CUR)
      param_w = mc_filt;
    else
      param_w = mem_rdata;
  end

  always_comb
  begin
    n = s;
    setup = psel_i && !penable_i;
    access = psel_i && penable_i;
    irq_set = '0;
    irq_clr = '0;
    rejoin = 1'b0;
    n.mem_we = 1'b0;
    n.words_valid = 1'b0;
    n.di_s1 = digital_input_i;
    n.di_s2 = s.di_s1;

    n.tick = 1'b0;
    if (s.tick_cnt == 17'(TICK_CYCLES - 1))
    begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end
    else
      n.tick_cnt = s.tick_cnt + 17'h00001;

    // read data is registered in the setup cycle and shown in the access cycle
    if (setup)
    begin
      n.pslverr = 1'b0;
      if (paddr_i == `OFF_CTRL)
        n.prdata = {25'h0000000, s.action, s.proto};
      else if (paddr_i == `OFF_STATUS)
        n.prdata = {22'h000000, family(s.proto), 1'b0, s.count, 2'b00, s.link};
      else if (paddr_i == `OFF_IRQ_STATUS)
        n.prdata = {29'h00000000, s.irq_st};
      else if (paddr_i == `OFF_IRQ_MASK)
        n.prdata = {29'h00000000, s.irq_mask};
      else if (paddr_i == `OFF_PARAM_ADDR)
        n.prdata = {22'h000000, s.param_addr};
      else if (paddr_i == `OFF_PARAM_DATA)
        n.prdata = 32'h00000000;
      else
      begin
        n.prdata = 32'h00000000;
        n.pslverr = 1'b1;
      end
    end

    if (access && pwrite_i)
    begin
      if (paddr_i == `OFF_CTRL)
      begin
        n.proto = pwdata_i[`CTRL_PROTO_MSB:`CTRL_PROTO_LSB];
        n.action = pwdata_i[`CTRL_ACT_MSB:`CTRL_ACT_LSB];
      end
      else if (paddr_i == `OFF_IRQ_STATUS)
        irq_clr = pwdata_i[`IRQ_W-1:0];
      else if (paddr_i == `OFF_IRQ_MASK)
        n.irq_mask = pwdata_i[`IRQ_W-1:0];
      else if (paddr_i == `OFF_PARAM_ADDR)
        n.param_addr = pwdata_i[`PMEM_AW-1:0];
      else if (paddr_i == `OFF_PARAM_DATA)
      begin
        n.mem_we = 1'b1;
        n.mem_waddr = s.param_addr;
        n.mem_wdata = pwdata_i[15:0];
        n.param_addr = s.param_addr + 10'h001;
      end
    end
    n.count = word_count(n.proto);
    active = (word_count(s.proto) != `CNT_0);

    case (s.link)
      LINK_IDLE:
      begin
        if (active && !board_ok_i)
          n.link = LINK_BOARD_OFF;
        else if (active && link_up_i)
          n.link = LINK_UP;
      end
      LINK_UP:
      begin
        if (!board_ok_i)
          n.link = LINK_BOARD_OFF;
        else if (!link_up_i)
          n.link = LINK_LOST;
      end
      LINK_LOST:
      begin
        if (!board_ok_i)
          n.link = LINK_BOARD_OFF;
        else if (link_up_i)
        begin
          n.link = LINK_UP;
          rejoin = 1'b1;
        end
      end
      default:
      begin
        // a repaired board needs a fresh connection before a loss counts
        if (board_ok_i)
        begin
          n.link = link_up_i ? LINK_UP : LINK_IDLE;
          rejoin = link_up_i;
        end
      end
    endcase
    if (!active)
      n.link = LINK_IDLE;
    if (n.link == LINK_LOST && s.link != LINK_LOST)
      irq_set[`IRQ_LINK_LOST] = 1'b1;
    if (n.link == LINK_BOARD_OFF && s.link != LINK_BOARD_OFF)
      irq_set[`IRQ_BOARD_OFF] = 1'b1;

    offline = (n.link == LINK_LOST) || (n.link == LINK_BOARD_OFF);
    n.act = offline ? (`ACT_ONEHOT << n.action) : 5'h00;

    if (rejoin)
    begin
      n.held_ctrl = '0;
      n.held_ref = '0;
    end
    else if (net_write_i && s.link == LINK_UP)
    begin
      n.held_ctrl = net_ctrl_i;
      n.held_ref = net_ref_i;
    end

    if (exchange_req_i && s.link == LINK_UP && s.count != `CNT_0)
    begin
      n.words = '0;
      n.words[0] = status_w;
      n.words[1] = speed_w;
      if (s.count >= `CNT_4)
      begin
        n.words[2] = image_w;
        n.words[3] = param_w;
      end
      if (s.count == `CNT_6)
      begin
        n.words[4] = tq_filt;
        n.words[5] = mc_filt;
      end
      n.words_valid = 1'b1;
      irq_set[`IRQ_EXCHANGE] = 1'b1;
    end

    // a new event outweighs a clear written in the same cycle
    n.irq_st = (s.irq_st & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      s <= '0;
    else if (ce_i)
      s <= n;
  end

  assign pready_o = 1'b1;
  assign prdata_o = s.prdata;
  assign pslverr_o = s.pslverr;
  assign irq_o = |(s.irq_st & s.irq_mask);
  assign word0_o = s.words[0];
  assign word1_o = s.words[1];
  assign word2_o = s.words[2];
  assign word3_o = s.words[3];
  assign word4_o = s.words[4];
  assign word5_o = s.words[5];
  assign words_valid_o = s.words_valid;
  assign word_count_o = s.count;
  assign held_ctrl_o = s.held_ctrl;
  assign held_ref_o = s.held_ref;
  assign ramp_stop_o = s.act[`ACT_RAMP];
  assign coast_stop_o = s.act[`ACT_COAST];
  assign keep_state_o = s.act[`ACT_KEEP];
  assign go_local_o = s.act[`ACT_LOCAL];
  assign go_local_keep_o = s.act[`ACT_LOCAL_KEEP];
  assign link_lost_error_o = (s.link == LINK_LOST);
  assign board_off_error_o = (s.link == LINK_BOARD_OFF);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_count_two: assert property ((s.proto == `PROTO_A_2 || s.proto == `PROTO_B_2 ||
    s.proto == `PROTO_C_2) |-> s.count == `CNT_2)
    else $error("two-word selection gives wrong count");
  a_count_six: assert property ((s.proto == `PROTO_A_6 || s.proto == `PROTO_B_6 ||
    s.proto == `PROTO_C_6) |-> s.count == `CNT_6)
    else $error("six-word selection gives wrong count");
  a_unsent_zero: assert property ((s.words_valid && s.count == `CNT_2) |->
    (s.words[2] == '0 && s.words[5] == '0))
    else $error("words beyond count not zero");
  a_action_ramp: assert property ((s.link == LINK_LOST && s.action == `ACT_RAMP) |->
    (ramp_stop_o && !coast_stop_o && !go_local_o))
    else $error("ramp stop not applied on link loss");
  a_online_none: assert property ((s.link == LINK_UP) |->
    !(ramp_stop_o || coast_stop_o || keep_state_o || go_local_o || go_local_keep_o))
    else $error("loss action active while online");
  a_held_clear: assert property ((ce_i && s.link == LINK_LOST && board_ok_i && link_up_i)
    |=> (s.link == LINK_UP && s.held_ctrl == '0 && s.held_ref == '0))
    else $error("held outputs not cleared on rejoin");
  a_status_flags: assert property ((ce_i && exchange_req_i && s.link == LINK_UP &&
    s.count != `CNT_0) |=> (s.words_valid && s.words[0][15] == $past(error_active_i) &&
    s.words[0][13] == $past(undervoltage_i) && s.words[0][8] == $past(run_i)))
    else $error("status word flags wrong");
  a_status_code: assert property ((ce_i && exchange_req_i && s.link == LINK_UP &&
    s.count != `CNT_0 && !error_active_i) |=> s.words[0][7:0] == 8'h00)
    else $error("fault code shown without fault");
  a_speed_sign: assert property ((ce_i && exchange_req_i && s.link == LINK_UP &&
    s.count != `CNT_0) |=> s.words[1] == ($past(cw_i) ? {3'b000, $past(speed_mag_i)} :
    16'(16'h0000 - {3'b000, $past(speed_mag_i)})))
    else $error("speed word sign wrong");
  a_lost_after_up: assert property ((ce_i && s.link != LINK_LOST) ##1
    (s.link == LINK_LOST) |-> $past(s.link) == LINK_UP)
    else $error("link-lost error without prior connection");
  a_board_off: assert property ((ce_i && s.link == LINK_UP && !board_ok_i && active)
    |=> (board_off_error_o && !link_lost_error_o))
    else $error("board failure not reported");
  a_one_capture: assert property (s.words_valid |-> $past(exchange_req_i))
    else $error("words captured without request");
  a_irq_sticky: assert property ((ce_i && irq_set[`IRQ_LINK_LOST]) |=>
    s.irq_st[`IRQ_LINK_LOST])
    else $error("link-lost event not latched");

  c_six_words: cover property (s.words_valid && s.count == `CNT_6);
  c_link_lost: cover property (s.link == LINK_UP ##1 s.link == LINK_LOST);
  c_rejoin: cover property (s.link == LINK_LOST ##[1:50] s.link == LINK_UP);
  c_board_off: cover property (s.link == LINK_BOARD_OFF);
endmodule // fieldbus_status_word_builder
`default_nettype wire

/* File: rtl/fsw_params.svh */
`ifndef FSW_PARAMS_SVH
`define FSW_PARAMS_SVH

`define APB_AW 12
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_IRQ_STATUS 12'h008
`define OFF_IRQ_MASK 12'h00C
`define OFF_PARAM_ADDR 12'h010
`define OFF_PARAM_DATA 12'h014

`define CTRL_PROTO_LSB 0
`define CTRL_PROTO_MSB 3
`define CTRL_ACT_LSB 4
`define CTRL_ACT_MSB 6
`define STAT_LINK_LSB 0
`define STAT_CNT_LSB 4
`define STAT_FAM_LSB 8

`define IRQ_W 3
`define IRQ_LINK_LOST 0
`define IRQ_BOARD_OFF 1
`define IRQ_EXCHANGE 2

`define PROTO_INACTIVE 4'h0
`define PROTO_A_2 4'h1
`define PROTO_A_6 4'h3
`define PROTO_B_2 4'h4
`define PROTO_B_6 4'h6
`define PROTO_C_2 4'h7
`define PROTO_C_6 4'h9
`define PROTO_B_PROFILE 4'hA

`define FAM_NONE 2'h0
`define FAM_A 2'h1
`define FAM_B 2'h2
`define FAM_C 2'h3

`define CNT_0 3'h0
`define CNT_2 3'h2
`define CNT_4 3'h4
`define CNT_6 3'h6

`define ACT_RAMP 3'h0
`define ACT_COAST 3'h1
`define ACT_KEEP 3'h2
`define ACT_LOCAL 3'h3
`define ACT_LOCAL_KEEP 3'h4
`define ACT_ONEHOT 5'h01

`define PNUM_MOTOR_CUR 10'h003
`define PNUM_DRIVE_STATE 10'h006
`define PNUM_TORQUE_CUR 10'h009
`define PNUM_INPUT_IMG 10'h00C

`define DSTATE_READY 16'h0000
`define DSTATE_RUN 16'h0001
`define DSTATE_UNDERVOLT 16'h0002
`define DSTATE_FAULT 16'h0003
`define FAULT_ACCESS_LO 8'h18
`define FAULT_ACCESS_HI 8'h1B

`define CLK_MHZ 100
`define FILT_TICK_US 1000
`define TAU_TORQUE_MS 500
`define TAU_MOTOR_MS 300
`define ALPHA_ONE 65536

`define PMEM_AW 10
`define PMEM_DEPTH 1024

`endif

/* File: rtl/fsw_pkg.sv */
`default_nettype none
package fsw_pkg;

  typedef logic [15:0] word_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_UP = 2'b01,
    LINK_LOST = 2'b11,
    LINK_BOARD_OFF = 2'b10
  } link_state_t;

  typedef struct packed {
    link_state_t link;
    logic [3:0] proto;
    logic [2:0] action;
    logic [2:0] count;
    logic [4:0] act;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic [9:0] param_addr;
    logic [31:0] prdata;
    logic pslverr;
    logic [7:0] di_s1;
    logic [7:0] di_s2;
    logic [5:0][15:0] words;
    logic words_valid;
    logic [15:0] held_ctrl;
    logic [15:0] held_ref;
    logic [16:0] tick_cnt;
    logic tick;
    logic mem_we;
    logic [9:0] mem_waddr;
    logic [15:0] mem_wdata;
  } core_state_t;

  typedef struct packed {
    logic signed [31:0] acc;
  } filt_state_t;

endpackage
`default_nettype wire

/* File: rtl/fsw_lp_filter.sv */
`timescale 1ns/1ns
`default_nettype none
module fsw_lp_filter #(
  parameter logic [16:0] ALPHA = 17'h00001
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic signed [15:0] x_i,
  output logic signed [15:0] y_o
);
  import fsw_pkg::*;

  filt_state_t s;
  filt_state_t n;
  logic signed [32:0] diff;
  logic signed [50:0] prod;

  // acc holds the output in Q16; one step moves it alpha of the way to x
  always_comb
  begin
    n = s;
    diff = 33'(signed'({x_i, 16'h0000})) - 33'(s.acc);
    prod = 51'(diff) * 51'(signed'({1'b0, ALPHA}));
    if (tick_i)
    begin
      n.acc = s.acc + prod[47:16];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      s <= '0;
    else if (ce_i)
      s <= n;
  end

  assign y_o = s.acc[31:16];
endmodule // fsw_lp_filter
`default_nettype wire

/* File: rtl/fsw_param_mem.sv */
`timescale 1ns/1ns
`include "fsw_params.svh"
`default_nettype none
module fsw_param_mem (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [9:0] waddr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [9:0] raddr_i,
  output logic [15:0] rdata_o
);
  import fsw_pkg::*;

  // the array stays outside the state struct so that it maps to block memory
  logic [15:0] mem [`PMEM_DEPTH];
  word_t rdata_q;
  word_t rdata_d;

  always_comb
  begin
    rdata_d = mem[raddr_i];
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i && we_i)
      mem[waddr_i] <= wdata_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rdata_q <= '0;
    else if (ce_i)
      rdata_q <= rdata_d;
  end

  assign rdata_o = rdata_q;
endmodule // fsw_param_mem
`default_nettype wire

/* File: testbench/fieldbus_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic connect_i,
  input wire logic poll_i,
  input wire logic [9:0] param_sel_i,
  input wire logic write_i,
  input wire logic [15:0] ctrl_i,
  output logic link_up_o,
  output logic exchange_req_o,
  output logic [9:0] param_num_o,
  output logic net_write_o,
  output logic [15:0] net_ctrl_o,
  output logic [15:0] net_ref_o
);
  logic [1:0] wait_q;
  logic busy_q;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      link_up_o <= 1'b0;
      exchange_req_o <= 1'b0;
      param_num_o <= 10'h000;
      net_write_o <= 1'b0;
      net_ctrl_o <= 16'h0000;
      net_ref_o <= 16'h0000;
      wait_q <= 2'h0;
      busy_q <= 1'b0;
    end
    else
    begin
      link_up_o <= connect_i;
      net_write_o <= write_i;
      // values off the write strobe are not held: show a changing pattern
      net_ctrl_o <= write_i ? ctrl_i : ~net_ctrl_o;
      net_ref_o <= write_i ? ~ctrl_i : ~net_ref_o;
      exchange_req_o <= 1'b0;
      if (poll_i && !busy_q)
      begin
        param_num_o <= param_sel_i;
        busy_q <= 1'b1;
        wait_q <= 2'h2;
      end
      else if (busy_q && wait_q == 2'h0)
      begin
        exchange_req_o <= 1'b1;
        busy_q <= 1'b0;
      end
      else if (busy_q)
        wait_q <= wait_q - 2'h1;
    end
  end
endmodule // fieldbus_master_model
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ns
`include "fsw_params.svh"
`default_nettype none
module tb;
  import fsw_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, rerr, valid, lost, boff;
  logic err = 0, aut = 0, uv = 0, rem = 0, jog = 0, cw = 0, en = 0, run = 0, bok = 1;
  logic [7:0] code = 8'h00, di = 8'h85;
  logic [12:0] mag = 13'h1FFF;
  logic conn = 0, poll = 0, wr = 0, link_up, xreq, nwr;
  logic [9:0] psel_num = 10'h000, pnum;
  logic [15:0] nctrl, nref;
  word_t w0, w1, w2, w3, w4, w5, hctrl, href;
  logic [2:0] cnt;
  logic [4:0] acts;
  int bad_count = 0, tests_run = 0;
  initial forever #5 clk_i = ~clk_i;
  fieldbus_master_model MST (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .connect_i(conn),
    .poll_i(poll), .param_sel_i(psel_num), .write_i(wr), .ctrl_i(16'h1234),
    .link_up_o(link_up), .exchange_req_o(xreq), .param_num_o(pnum), .net_write_o(nwr),
    .net_ctrl_o(nctrl), .net_ref_o(nref));
  fieldbus_status_word_builder #(.TICK_CYCLES(4)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(1'b1), .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .irq_o(irq), .error_active_i(err), .regulator_auto_i(aut), .undervoltage_i(uv),
    .remote_i(rem), .jog_i(jog), .cw_i(cw), .gen_enable_i(en), .run_i(run),
    .fault_code_i(code), .speed_mag_i(mag), .torque_current_i(16'sh0100),
    .motor_current_i(16'sh0080), .digital_input_i(di), .link_up_i(link_up),
    .board_ok_i(bok), .exchange_req_i(xreq), .param_num_i(pnum), .net_write_i(nwr),
    .net_ctrl_i(nctrl), .net_ref_i(nref), .word0_o(w0), .word1_o(w1), .word2_o(w2),
    .word3_o(w3), .word4_o(w4), .word5_o(w5), .words_valid_o(valid), .word_count_o(cnt),
    .held_ctrl_o(hctrl), .held_ref_o(href), .ramp_stop_o(acts[0]), .coast_stop_o(acts[1]),
    .keep_state_o(acts[2]), .go_local_o(acts[3]), .go_local_keep_o(acts[4]),
    .link_lost_error_o(lost), .board_off_error_o(boff));
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      bad_count++;
      give_verdict();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so that the next call never re-assigns psel in this time step
    @(posedge clk_i);
  endtask
  task wait_flag(input int sel);
    int n;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk_i);
      #1;
      if ((sel == 0 && valid === 1'b1) || (sel == 1 && lost === 1'b1) ||
          (sel == 2 && boff === 1'b1))
        return;
    end
    bad_count++;
    give_verdict();
  endtask
  task ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task do_poll(input logic [9:0] p);
    psel_num <= p;
    poll <= 1'b1;
    @(posedge clk_i);
    poll <= 1'b0;
    wait_flag(0);
  endtask
  task t_regs;
    int p;
    logic [31:0] e;
    apb(1, `OFF_CTRL, 32'h13);
    apb(0, `OFF_CTRL, 0);
    check("ctrl", rd, 32'h13);
    apb(0, 12'h018, 0);
    check("unmapped", {rerr, rd[30:0]}, 32'h80000000);
    for (p = 0; p <= 10; p++)
    begin
      e = p == 0 ? 0 : p == 10 ? 32'h240 : (((p - 1) / 3 + 1) << 8) | ((((p - 1) % 3) * 2 + 2) << 4);
      apb(1, `OFF_CTRL, p);
      apb(0, `OFF_STATUS, 0);
      check("decode", rd & 32'h3F0, e);
    end
  endtask
  task t_words;
    apb(1, `OFF_CTRL, 32'h03);
    ticks(4);
    check("no early loss", lost, 0);
    conn <= 1'b1;
    ticks(3);
    {err, aut, uv, rem, jog, cw, en, run, code} <= {8'b10110011, 8'h09};
    apb(1, `OFF_PARAM_ADDR, 32'h064);
    apb(1, `OFF_PARAM_DATA, 32'h0514);
    do_poll(10'h064);
    check("status", w0, 16'hB309);
    check("speed ccw", w1, 16'hE001);
    check("image", w2, 16'h00A1);
    check("param", w3, 16'h0514);
    check("count", cnt, 6);
    {err, cw} <= 2'b01;
    do_poll(10'h006);
    check("status ok", w0, 16'h3700);
    check("speed cw", w1, 16'h1FFF);
    check("state uv", w3, 16'h0002);
    {err, uv, code} <= {2'b10, 8'h18};
    do_poll(10'h006);
    check("state access", w3, 16'h0001);
    code <= 8'h05;
    do_poll(10'h006);
    check("state fault", w3, 16'h0003);
    {err, run} <= 2'b00;
    do_poll(10'h006);
    check("state ready", w3, 16'h0000);
    apb(1, `OFF_CTRL, 32'h01);
    do_poll(10'h006);
    check("count2", cnt, 3'h2);
    check("count2 w2 w3", {w2, w3}, 32'h0);
    check("count2 w4 w5", {w4, w5}, 32'h0);
  endtask
  task t_loss;
    int a;
    for (a = 0; a < 5; a++)
    begin
      apb(1, `OFF_CTRL, (a << 4) | 3);
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
      ticks(3);
      check("held", hctrl, 16'h1234);
      check("held ref", href, 16'hEDCB);
      conn <= 1'b0;
      wait_flag(1);
      check("action", acts, 5'h01 << a);
      conn <= 1'b1;
      ticks(3);
      check("cleared", {hctrl, 15'h0, lost}, 0);
    end
    apb(1, `OFF_IRQ_MASK, 0);
    check("irq masked", irq, 0);
    apb(1, `OFF_IRQ_MASK, 1);
    ticks(1);
    check("irq on", irq, 1);
    apb(1, `OFF_IRQ_STATUS, 1);
    ticks(1);
    check("irq clear", irq, 0);
    bok <= 1'b0;
    wait_flag(2);
    check("board off", {lost, acts}, 6'h10);
    apb(0, `OFF_IRQ_STATUS, 0);
    check("irq board", rd[1], 1);
    bok <= 1'b1;
  endtask
  initial
  begin
    ticks(5);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_words();
    t_loss();
    give_verdict();
  end
endmodule // tb
`default_nettype wire
